// file: src/cprs_addr_dec.sv
// Data address extension and area decode
module cprs_addr_dec (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [15:0] addr16,
	input wire logic use_bank,
	input wire logic [3:0] bank,
	output logic [19:0] addr20,
	output logic in_gpr,
	output logic in_periph
);
	logic [19:0] next_addr20;
	// plain addresses sit in top 64 KB
	assign next_addr20 = {use_bank ? bank : cprs_pkg::PLAIN_BANK, addr16};
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			addr20 <= 20'h00000;
			in_gpr <= 1'b0;
			in_periph <= 1'b0;
		end else begin
			addr20 <= next_addr20;
			in_gpr <= next_addr20 >= cprs_pkg::GPR_BASE && next_addr20 <= cprs_pkg::GPR_LAST;
			in_periph <= next_addr20 >= cprs_pkg::PERIPH_BASE && next_addr20 <= cprs_pkg::PERIPH_LAST;
		end
	end
endmodule

// file: src/cprs_core_regs.sv
// Processor register set: status word, stack pointer, banks, registers
// Function
// - Refuse interrupts of priority lower than the in-service level.
// - Gate every vectored acknowledge with the interrupt enable flag.
// - Carry catches add overflow and subtract underflow.
// - Carry takes rotate shift-out, acts as bit accumulator.
// - Sixteen-bit stack pointer; stack lives only in internal RAM.
// - Decrement stack pointer before push, increment after pop.
// - Stack pointer undefined after reset; software loads it.
// - Eight byte registers mapped at FFEF8H to FFEFFH.
// - Byte registers also accessed as four 16-bit pairs.
// - Data bank extends data addresses; branch bank extends register branches.
// - Reset data bank to 0FH, branch bank to 00H.
// - Bank registers eight bits, upper four fixed zero.
// - Plain addresses reach F0000H up; banked reach whole space.
// - Decode peripheral area FFF00H to FFFFFH.
// - Peripheral access in 1-bit or 8-bit units per register.
// - Reset loads PC low from vector bytes, clears top bits.
// - Reset sets status word to 06H.
// - Disable or acknowledge clears enable; enable instruction sets.
//
// The implementer's own choices: the plain strobed port and the address map.
module cprs_core_regs (
	input wire logic mclk,
	input wire logic rst_n,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// Interrupt request from the controller
	input wire logic int_req,
	input wire logic [1:0] int_level,
	input wire logic ei_exec,
	input wire logic di_exec,
	input wire logic isp_load,
	input wire logic [1:0] isp_value,
	output logic int_ack,
	// Carry update
	input wire cprs_pkg::cprs_cyop_t cy_op,
	input wire logic cy_in,
	output logic carry_flag,
	// Stack pointer
	input wire cprs_pkg::cprs_spop_t sp_op,
	input wire logic [15:0] sp_load,
	output logic [15:0] stack_pointer,
	output logic [15:0] stack_addr,
	// Data access address path
	input wire logic [15:0] data_addr16,
	input wire logic data_use_bank,
	output logic [19:0] data_addr20,
	output logic data_in_gpr,
	output logic data_in_periph,
	input wire logic periph_bit_access,
	input wire logic periph_bit_ok,
	output logic periph_unit_err,
	// Register-direct branch
	input wire logic [15:0] branch_addr16,
	input wire logic branch_exec,
	// Reset vector fetch
	input wire logic [7:0] vec_data,
	output logic [15:0] vec_addr,
	output logic [19:0] program_counter,
	output logic pc_ready,
	// General register pair port
	input wire logic [1:0] pair_sel,
	input wire logic [15:0] pair_wdata,
	input wire logic pair_wr,
	output logic [15:0] pair_rdata
);
	typedef enum logic [1:0] {CPRS_VEC_LO, CPRS_VEC_HI, CPRS_RUN} cprs_boot_t;
	cprs_boot_t boot;
	logic interrupt_enable_flag;
	logic in_service_priority_high;
	logic in_service_priority_low;
	logic [3:0] data_bank;
	logic [3:0] branch_bank;
	logic [7:0] program_status_word;
	logic gpr_wr;
	logic [1:0] isp;
	logic take;
	logic [7:0] rd_mux;

	assign isp = {in_service_priority_high, in_service_priority_low};
	assign program_status_word = {interrupt_enable_flag, 4'h0, in_service_priority_high, in_service_priority_low, carry_flag};
	// level must not be lower than in-service
	assign take = int_req && interrupt_enable_flag && (int_level <= isp) && boot == CPRS_RUN;
	assign gpr_wr = reg_wr && reg_addr[7:3] == cprs_pkg::REG_GPR_BASE[7:3];

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			int_ack <= 1'b0;
		end else begin
			int_ack <= take;
		end
	end

	// Enable flag and in-service levels
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			interrupt_enable_flag <= cprs_pkg::PSW_RESET[cprs_pkg::PSW_IE_BIT];
			in_service_priority_high <= cprs_pkg::PSW_RESET[cprs_pkg::PSW_IN_SERVICE_PRIORITY_HIGH_BIT];
			in_service_priority_low <= cprs_pkg::PSW_RESET[cprs_pkg::PSW_IN_SERVICE_PRIORITY_LOW_BIT];
		end else begin
			// acknowledge and disable clear, enable sets
			if (take || di_exec) begin
				interrupt_enable_flag <= 1'b0;
			end else if (ei_exec) begin
				interrupt_enable_flag <= 1'b1;
			end else if (reg_wr && reg_addr == cprs_pkg::REG_PSW) begin
				interrupt_enable_flag <= reg_wdata[cprs_pkg::PSW_IE_BIT];
			end
			// Acknowledge raises in-service level to the accepted one
			if (take) begin
				{in_service_priority_high, in_service_priority_low} <= int_level;
			end else if (isp_load) begin
				{in_service_priority_high, in_service_priority_low} <= isp_value;
			end else if (reg_wr && reg_addr == cprs_pkg::REG_PSW) begin
				in_service_priority_high <= reg_wdata[cprs_pkg::PSW_IN_SERVICE_PRIORITY_HIGH_BIT];
				in_service_priority_low <= reg_wdata[cprs_pkg::PSW_IN_SERVICE_PRIORITY_LOW_BIT];
			end
		end
	end

	// Carry flag
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			carry_flag <= cprs_pkg::PSW_RESET[cprs_pkg::PSW_CY_BIT];
		end else begin
			case (cy_op)
				cprs_pkg::CPRS_CY_ARITH: begin
					carry_flag <= cy_in;
				end
				cprs_pkg::CPRS_CY_ROT, cprs_pkg::CPRS_CY_BIT: begin
					carry_flag <= cy_in;
				end
				default: begin
					if (reg_wr && reg_addr == cprs_pkg::REG_PSW) begin
						carry_flag <= reg_wdata[cprs_pkg::PSW_CY_BIT];
					end
				end
			endcase
		end
	end

	// Stack pointer has no reset: contents undefined until loaded
	// no reset branch
	always_ff @(posedge mclk) begin
		case (sp_op)
			cprs_pkg::CPRS_SP_PUSH: begin
				stack_pointer <= stack_pointer - 16'h0001;
				stack_addr <= stack_pointer - 16'h0001;
			end
			cprs_pkg::CPRS_SP_POP: begin
				stack_pointer <= stack_pointer + 16'h0001;
				stack_addr <= stack_pointer;
			end
			cprs_pkg::CPRS_SP_LOAD: begin
				stack_pointer <= sp_load;
				stack_addr <= sp_load;
			end
			default: begin
				if (reg_wr && reg_addr == cprs_pkg::REG_SP_LO) begin
					stack_pointer[7:0] <= reg_wdata;
				end else if (reg_wr && reg_addr == cprs_pkg::REG_SP_HI) begin
					stack_pointer[15:8] <= reg_wdata;
				end
			end
		endcase
	end

	// Bank registers
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			data_bank <= cprs_pkg::DBANK_RESET[3:0];
			branch_bank <= cprs_pkg::BBANK_RESET[3:0];
		end else begin
			if (reg_wr && reg_addr == cprs_pkg::REG_DBANK) begin
				data_bank <= reg_wdata[3:0] & cprs_pkg::BANK_FIELD_MASK;
			end
			if (reg_wr && reg_addr == cprs_pkg::REG_BBANK) begin
				branch_bank <= reg_wdata[3:0] & cprs_pkg::BANK_FIELD_MASK;
			end
		end
	end

	// Reset vector fetch, then branches
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			boot <= CPRS_VEC_LO;
			vec_addr <= cprs_pkg::RESET_VEC_LO;
			program_counter <= 20'h00000;
			pc_ready <= 1'b0;
		end else begin
			case (boot)
				// low byte from 0000H, top bits cleared
				CPRS_VEC_LO: begin
					program_counter <= {4'h0, 8'h00, vec_data};
					vec_addr <= cprs_pkg::RESET_VEC_HI;
					boot <= CPRS_VEC_HI;
				end
				CPRS_VEC_HI: begin
					program_counter[15:8] <= vec_data;
					pc_ready <= 1'b1;
					boot <= CPRS_RUN;
				end
				default: begin
					if (branch_exec) begin
						program_counter <= {branch_bank, branch_addr16};
					end
				end
			endcase
		end
	end

	// data bank supplies data upper bits
	cprs_addr_dec u_dec (
		.mclk(mclk),
		.rst_n(rst_n),
		.addr16(data_addr16),
		.use_bank(data_use_bank),
		.bank(data_bank),
		.addr20(data_addr20),
		.in_gpr(data_in_gpr),
		.in_periph(data_in_periph)
	);

	// bit access only where the register allows it
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			periph_unit_err <= 1'b0;
		end else begin
			// Bank F reaches the same area, so banked accesses are checked too
			periph_unit_err <= periph_bit_access && !periph_bit_ok
				&& data_addr16[15:8] == cprs_pkg::PERIPH_BASE[15:8]
				&& (!data_use_bank || data_bank == cprs_pkg::PLAIN_BANK);
		end
	end

	// pair and byte access to general registers
	cprs_gpr_mem #(
		.NREG(8)
	) u_gpr (
		.mclk(mclk),
		.rst_n(rst_n),
		.waddr(reg_addr[2:0]),
		.wdata(reg_wdata),
		.wbyte(gpr_wr),
		.wpair(pair_sel),
		.wpdata(pair_wdata),
		.wpair_en(pair_wr),
		.raddr(reg_addr[2:0]),
		.rpair(pair_sel),
		.rdata(),
		.rpdata(pair_rdata)
	);

	// Read port; general register bytes are read back through the pair port
	always_comb begin
		rd_mux = 8'h00;
		if (reg_addr == cprs_pkg::REG_PSW) begin
			rd_mux = program_status_word;
		end else if (reg_addr == cprs_pkg::REG_SP_LO) begin
			rd_mux = stack_pointer[7:0];
		end else if (reg_addr == cprs_pkg::REG_SP_HI) begin
			rd_mux = stack_pointer[15:8];
		end else if (reg_addr == cprs_pkg::REG_DBANK) begin
			rd_mux = {4'h0, data_bank};
		end else if (reg_addr == cprs_pkg::REG_BBANK) begin
			rd_mux = {4'h0, branch_bank};
		end else if (reg_addr == cprs_pkg::REG_PC_LO) begin
			rd_mux = program_counter[7:0];
		end else if (reg_addr == cprs_pkg::REG_PC_MID) begin
			rd_mux = program_counter[15:8];
		end else if (reg_addr == cprs_pkg::REG_PC_HI) begin
			rd_mux = {4'h0, program_counter[19:16]};
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			reg_rdata <= 8'h00;
		end else begin
			reg_rdata <= reg_rd ? rd_mux : 8'h00;
		end
	end

	// Assertions
	a_prio_block: assert property (@(posedge mclk) disable iff (!rst_n)
		int_level > isp |=> !int_ack) else $error("Lower priority acknowledged");
	a_ie_gate: assert property (@(posedge mclk) disable iff (!rst_n)
		!interrupt_enable_flag |=> !int_ack) else $error("Acknowledge with enable low");
	a_ack_clears: assert property (@(posedge mclk) disable iff (!rst_n)
		int_ack |-> !interrupt_enable_flag) else $error("Enable not cleared by acknowledge");
	a_carry_load: assert property (@(posedge mclk) disable iff (!rst_n)
		cy_op != cprs_pkg::CPRS_CY_NONE |=> carry_flag == $past(cy_in)) else $error("Carry not captured");
	a_sp_push: assert property (@(posedge mclk) disable iff (!rst_n)
		sp_op == cprs_pkg::CPRS_SP_PUSH |=> stack_pointer == $past(stack_pointer) - 16'h0001
		&& stack_addr == stack_pointer) else $error("Push not predecrement");
	a_sp_load: assert property (@(posedge mclk) disable iff (!rst_n)
		sp_op == cprs_pkg::CPRS_SP_LOAD |=> stack_pointer == $past(sp_load)) else $error("Stack load lost");
	a_sp_pop: assert property (@(posedge mclk) disable iff (!rst_n)
		sp_op == cprs_pkg::CPRS_SP_POP |=> stack_pointer == $past(stack_pointer) + 16'h0001)
		else $error("Pop not postincrement");
	a_bank_zero: assert property (@(posedge mclk) disable iff (!rst_n)
		reg_rd && reg_addr == cprs_pkg::REG_DBANK |=> reg_rdata[7:4] == 4'h0) else $error("Bank top nonzero");
	a_bank_reset: assert property (@(posedge mclk)
		!rst_n |=> data_bank == 4'hF && branch_bank == 4'h0) else $error("Bank reset wrong");
	a_pc_boot: assert property (@(posedge mclk) disable iff (!rst_n)
		rst_n && boot == CPRS_VEC_LO |=> program_counter[19:16] == 4'h0 ##1 pc_ready) else $error("Boot fetch wrong");
	a_ext_addr: assert property (@(posedge mclk) disable iff (!rst_n)
		data_use_bank |=> data_addr20 == {$past(data_bank), $past(data_addr16)}) else $error("Extension wrong");
	a_ie_set: assert property (@(posedge mclk) disable iff (!rst_n)
		ei_exec && !di_exec && !take |=> interrupt_enable_flag) else $error("Enable not set");
	a_di_clear: assert property (@(posedge mclk) disable iff (!rst_n)
		di_exec |=> !interrupt_enable_flag) else $error("Disable did not clear enable");
	a_isp_take: assert property (@(posedge mclk) disable iff (!rst_n)
		take |=> isp == $past(int_level)) else $error("In-service level not raised");
	a_periph_ok: assert property (@(posedge mclk) disable iff (!rst_n)
		periph_bit_access && periph_bit_ok |=> !periph_unit_err) else $error("Allowed bit access flagged");
	a_plain_addr: assert property (@(posedge mclk) disable iff (!rst_n)
		rst_n && !data_use_bank |=> data_addr20[19:16] == cprs_pkg::PLAIN_BANK)
		else $error("Plain address outside top");
	a_periph_area: assert property (@(posedge mclk) disable iff (!rst_n)
		data_in_periph |-> data_addr20 >= cprs_pkg::PERIPH_BASE) else $error("Peripheral decode outside area");
	a_gpr_window: assert property (@(posedge mclk) disable iff (!rst_n)
		data_in_gpr |-> data_addr20 >= cprs_pkg::GPR_BASE && data_addr20 <= cprs_pkg::GPR_LAST)
		else $error("Register window decode wrong");
	a_bank_write: assert property (@(posedge mclk) disable iff (!rst_n)
		reg_wr && reg_addr == cprs_pkg::REG_DBANK |=> data_bank == $past(reg_wdata[3:0]))
		else $error("Bank write lost");
	a_pc_branch: assert property (@(posedge mclk) disable iff (!rst_n)
		branch_exec && boot == CPRS_RUN |=> program_counter == {$past(branch_bank), $past(branch_addr16)})
		else $error("Branch bank not applied");
endmodule

// file: src/cprs_gpr_mem.sv
// Eight-byte general register bank with byte and pair ports
module cprs_gpr_mem #(
	parameter int NREG = 8
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [2:0] waddr,
	input wire logic [7:0] wdata,
	input wire logic wbyte,
	input wire logic [1:0] wpair,
	input wire logic [15:0] wpdata,
	input wire logic wpair_en,
	input wire logic [2:0] raddr,
	input wire logic [1:0] rpair,
	output logic [7:0] rdata,
	output logic [15:0] rpdata
);
	logic [7:0] mem [NREG];
	genvar g;
	generate
		for (g = 0; g < NREG; g++) begin : g_reg
			always_ff @(posedge mclk) begin
				if (!rst_n) begin
					mem[g] <= 8'h00;
				end else if (wpair_en && wpair == 2'(g / 2)) begin
					mem[g] <= (g % 2 == 1) ? wpdata[15:8] : wpdata[7:0];
				end else if (wbyte && waddr == 3'(g)) begin
					mem[g] <= wdata;
				end
			end
		end
	endgenerate
	always_ff @(posedge mclk) begin
		rdata <= mem[raddr];
		rpdata <= {mem[{rpair, 1'b1}], mem[{rpair, 1'b0}]};
	end
endmodule

// file: src/cprs_pkg.sv
// Package of constants for the processor register set
package cprs_pkg;
	localparam logic [7:0] PSW_RESET = 8'h06;
	localparam int PSW_IE_BIT = 7;
	localparam int PSW_IN_SERVICE_PRIORITY_HIGH_BIT = 2;
	localparam int PSW_IN_SERVICE_PRIORITY_LOW_BIT = 1;
	localparam int PSW_CY_BIT = 0;
	localparam logic [7:0] DBANK_RESET = 8'h0F;
	localparam logic [7:0] BBANK_RESET = 8'h00;
	localparam logic [3:0] BANK_FIELD_MASK = 4'hF;
	localparam logic [19:0] GPR_BASE = 20'hFFEF8;
	localparam logic [19:0] GPR_LAST = 20'hFFEFF;
	localparam logic [19:0] PERIPH_BASE = 20'hFFF00;
	localparam logic [19:0] PERIPH_LAST = 20'hFFFFF;
	localparam logic [3:0] PLAIN_BANK = 4'hF;
	localparam logic [15:0] RESET_VEC_LO = 16'h0000;
	localparam logic [15:0] RESET_VEC_HI = 16'h0001;
	// Register port offsets
	localparam logic [7:0] REG_PSW = 8'h00;
	localparam logic [7:0] REG_SP_LO = 8'h01;
	localparam logic [7:0] REG_SP_HI = 8'h02;
	localparam logic [7:0] REG_DBANK = 8'h03;
	localparam logic [7:0] REG_BBANK = 8'h04;
	localparam logic [7:0] REG_GPR_BASE = 8'h08;
	localparam logic [7:0] REG_PC_LO = 8'h10;
	localparam logic [7:0] REG_PC_MID = 8'h11;
	localparam logic [7:0] REG_PC_HI = 8'h12;
	typedef enum logic [1:0] {CPRS_CY_NONE, CPRS_CY_ARITH, CPRS_CY_ROT, CPRS_CY_BIT} cprs_cyop_t;
	typedef enum logic [1:0] {CPRS_SP_HOLD, CPRS_SP_PUSH, CPRS_SP_POP, CPRS_SP_LOAD} cprs_spop_t;
endpackage

// file: verification/cprs_vec_rom.sv
// Reset vector store that answers the register set's vector fetch
module cprs_vec_rom #(
	parameter logic [15:0] VECTOR = 16'h2345
) (
	input wire logic [15:0] vec_addr,
	output logic [7:0] vec_data
);
	timeunit 1ns;
	timeprecision 1ns;
	always_comb begin
		case (vec_addr)
			16'h0000: vec_data = VECTOR[7:0];
			16'h0001: vec_data = VECTOR[15:8];
			// A changing pattern elsewhere so a fetch from the wrong place cannot match
			default: vec_data = vec_addr[7:0] ^ 8'hA5;
		endcase
	end
endmodule

// file: verification/test_cpu_processor_register_set.sv
// Self-checking bench for the processor register set
module test_cpu_processor_register_set;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_rdata;
	logic int_req = 1'b0;
	logic [1:0] int_level = 2'h0;
	logic ei_exec = 1'b0;
	logic di_exec = 1'b0;
	logic isp_load = 1'b0;
	logic [1:0] isp_value = 2'h0;
	logic int_ack;
	cprs_pkg::cprs_cyop_t cy_op = cprs_pkg::CPRS_CY_NONE;
	logic cy_in = 1'b0;
	logic carry_flag;
	cprs_pkg::cprs_spop_t sp_op = cprs_pkg::CPRS_SP_HOLD;
	logic [15:0] sp_load = 16'h0000;
	logic [15:0] stack_pointer;
	logic [15:0] stack_addr;
	logic [15:0] data_addr16 = 16'h0000;
	logic data_use_bank = 1'b0;
	logic [19:0] data_addr20;
	logic data_in_gpr;
	logic data_in_periph;
	logic periph_bit_access = 1'b0;
	logic periph_bit_ok = 1'b0;
	logic periph_unit_err;
	logic [15:0] branch_addr16 = 16'h0000;
	logic branch_exec = 1'b0;
	logic [7:0] vec_data;
	logic [15:0] vec_addr;
	logic [19:0] program_counter;
	logic pc_ready;
	logic [1:0] pair_sel = 2'h0;
	logic [15:0] pair_wdata = 16'h0000;
	logic pair_wr = 1'b0;
	logic [15:0] pair_rdata;
	int mismatches = 0;
	int checks_done = 0;
	int cycles = 0;
	int acks = 0;

	always #20 mclk = ~mclk;

	cprs_vec_rom #(.VECTOR(16'h2345)) cprs_vec_rom_i (.vec_addr(vec_addr), .vec_data(vec_data));

	cprs_core_regs cprs_core_regs_i (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .int_req(int_req), .int_level(int_level),
		.ei_exec(ei_exec), .di_exec(di_exec), .isp_load(isp_load), .isp_value(isp_value), .int_ack(int_ack),
		.cy_op(cy_op), .cy_in(cy_in), .carry_flag(carry_flag), .sp_op(sp_op), .sp_load(sp_load),
		.stack_pointer(stack_pointer), .stack_addr(stack_addr), .data_addr16(data_addr16),
		.data_use_bank(data_use_bank), .data_addr20(data_addr20), .data_in_gpr(data_in_gpr),
		.data_in_periph(data_in_periph), .periph_bit_access(periph_bit_access), .periph_bit_ok(periph_bit_ok),
		.periph_unit_err(periph_unit_err),
		.branch_addr16(branch_addr16), .branch_exec(branch_exec), .vec_data(vec_data), .vec_addr(vec_addr),
		.program_counter(program_counter), .pc_ready(pc_ready), .pair_sel(pair_sel), .pair_wdata(pair_wdata),
		.pair_wr(pair_wr), .pair_rdata(pair_rdata));

	always @(posedge mclk) begin
		if (int_ack === 1'b1) begin
			acks++;
		end
	end

	task automatic check(input logic [19:0] seen, input logic [19:0] exp);
		checks_done++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic close_out();
		$display("Checks %0d, mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// Runaway guard: the whole sequence needs about a hundred cycles
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 3000) begin
			mismatches++;
			close_out();
		end
	end

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge mclk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 check(20'(reg_rdata), 20'(exp));
	endtask

	task automatic pulse_ie(input logic en);
		@(posedge mclk);
		ei_exec <= en;
		di_exec <= ~en;
		@(posedge mclk);
		ei_exec <= 1'b0;
		di_exec <= 1'b0;
	endtask

	task automatic dec(input logic [15:0] a, input logic ub, input logic [19:0] e, input logic g, input logic p);
		@(posedge mclk);
		data_addr16 <= a;
		data_use_bank <= ub;
		@(posedge mclk);
		#1 check(data_addr20, e);
		check(20'({data_in_gpr, data_in_periph}), 20'({g, p}));
	endtask

	task automatic t_reset();
		repeat (3) @(posedge mclk);
		#1 check(20'(pc_ready), 20'h00001);
		check(program_counter, 20'h02345);
		rd(cprs_pkg::REG_PSW, 8'h06);
		rd(cprs_pkg::REG_DBANK, 8'h0F);
		rd(cprs_pkg::REG_BBANK, 8'h00);
	endtask

	task automatic t_bank_addr();
		wr(cprs_pkg::REG_DBANK, 8'hA3);
		rd(cprs_pkg::REG_DBANK, 8'h03);
		rd(8'h07, 8'h00);
		dec(16'hFEF8, 1'b0, 20'hFFEF8, 1'b1, 1'b0);
		dec(16'hFEFF, 1'b0, 20'hFFEFF, 1'b1, 1'b0);
		dec(16'hFEF7, 1'b0, 20'hFFEF7, 1'b0, 1'b0);
		dec(16'hFF00, 1'b0, 20'hFFF00, 1'b0, 1'b1);
		dec(16'hFF00, 1'b1, 20'h3FF00, 1'b0, 1'b0);
		dec(16'h1234, 1'b1, 20'h31234, 1'b0, 1'b0);
	endtask

	task automatic t_periph();
		@(posedge mclk);
		data_addr16 <= 16'hFF20;
		data_use_bank <= 1'b0;
		periph_bit_access <= 1'b1;
		periph_bit_ok <= 1'b0;
		@(posedge mclk);
		periph_bit_ok <= 1'b1;
		#1 check(20'(periph_unit_err), 20'h00001);
		@(posedge mclk);
		data_addr16 <= 16'h1220;
		periph_bit_ok <= 1'b0;
		#1 check(20'(periph_unit_err), 20'h00000);
		@(posedge mclk);
		periph_bit_access <= 1'b0;
		#1 check(20'(periph_unit_err), 20'h00000);
	endtask

	task automatic t_stack();
		@(posedge mclk);
		sp_op <= cprs_pkg::CPRS_SP_LOAD;
		sp_load <= 16'h1000;
		@(posedge mclk);
		sp_op <= cprs_pkg::CPRS_SP_PUSH;
		#1 check(20'(stack_pointer), 20'h01000);
		@(posedge mclk);
		sp_op <= cprs_pkg::CPRS_SP_POP;
		#1 check(20'(stack_pointer), 20'h00FFF);
		check(20'(stack_addr), 20'h00FFF);
		@(posedge mclk);
		sp_op <= cprs_pkg::CPRS_SP_HOLD;
		#1 check(20'(stack_pointer), 20'h01000);
		check(20'(stack_addr), 20'h00FFF);
	endtask

	task automatic t_carry();
		cprs_pkg::cprs_cyop_t ops [4];
		logic [3:0] vals;
		ops = '{cprs_pkg::CPRS_CY_ARITH, cprs_pkg::CPRS_CY_ROT, cprs_pkg::CPRS_CY_BIT, cprs_pkg::CPRS_CY_ARITH};
		vals = 4'h5;
		for (int i = 0; i < 4; i++) begin
			@(posedge mclk);
			cy_op <= ops[i];
			cy_in <= vals[i];
			@(posedge mclk);
			cy_op <= cprs_pkg::CPRS_CY_NONE;
			cy_in <= 1'b1;
			#1 check(20'(carry_flag), 20'(vals[i]));
		end
		@(posedge mclk);
		#1 check(20'(carry_flag), 20'h00000);
	endtask

	task automatic t_int();
		@(posedge mclk);
		int_req <= 1'b1;
		int_level <= 2'h0;
		repeat (3) @(posedge mclk);
		int_req <= 1'b0;
		#1 check(20'(acks), 20'h00000);
		pulse_ie(1'b1);
		rd(cprs_pkg::REG_PSW, 8'h86);
		pulse_ie(1'b0);
		rd(cprs_pkg::REG_PSW, 8'h06);
		pulse_ie(1'b1);
		@(posedge mclk);
		int_req <= 1'b1;
		int_level <= 2'h1;
		@(posedge mclk);
		int_req <= 1'b0;
		#1 check(20'(int_ack), 20'h00001);
		rd(cprs_pkg::REG_PSW, 8'h02);
		pulse_ie(1'b1);
		@(posedge mclk);
		int_req <= 1'b1;
		int_level <= 2'h2;
		repeat (3) @(posedge mclk);
		int_level <= 2'h1;
		@(posedge mclk);
		int_req <= 1'b0;
		#1 check(20'(int_ack), 20'h00001);
		@(posedge mclk);
		isp_load <= 1'b1;
		isp_value <= 2'h3;
		#1 check(20'(acks), 20'h00002);
		@(posedge mclk);
		isp_load <= 1'b0;
		rd(cprs_pkg::REG_PSW, 8'h06);
	endtask

	task automatic t_pair_branch();
		@(posedge mclk);
		pair_wr <= 1'b1;
		pair_sel <= 2'h1;
		pair_wdata <= 16'h1234;
		@(posedge mclk);
		pair_wr <= 1'b0;
		repeat (2) @(posedge mclk);
		#1 check(20'(pair_rdata), 20'h01234);
		wr(cprs_pkg::REG_GPR_BASE + 8'h04, 8'h5A);
		@(posedge mclk);
		pair_sel <= 2'h2;
		repeat (2) @(posedge mclk);
		#1 check(20'(pair_rdata), 20'h0005A);
		wr(cprs_pkg::REG_BBANK, 8'hFB);
		rd(cprs_pkg::REG_BBANK, 8'h0B);
		@(posedge mclk);
		branch_exec <= 1'b1;
		branch_addr16 <= 16'h4321;
		@(posedge mclk);
		branch_exec <= 1'b0;
		#1 check(program_counter, 20'hB4321);
	endtask

	initial begin
		repeat (5) @(posedge mclk);
		rst_n <= 1'b1;
		t_reset();
		t_bank_addr();
		t_periph();
		t_stack();
		t_carry();
		t_int();
		t_pair_branch();
		close_out();
	end
endmodule
